// [bench/lss_analog_model.sv]
// Behavioural model of the analog side: delay pins and rail output monitors.
// Assumes the core's delay pin controls and rail enables are registered on clk.
`timescale 1ns/1ps
module lss_analog_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // From the core
  input wire logic [lss_pkg::NUM_RAILS-1:0] rail_ctrl_en,
  input wire logic [lss_pkg::NUM_RAILS-1:0] soft_start_done,
  input wire logic rail_delay_pin_source_en,
  input wire logic rail_delay_pin_discharge_en,
  // To the core
  output logic [lss_pkg::NUM_RAILS-1:0] rail_below_uv,
  output logic [lss_pkg::NUM_SEQ-1:0] rail_delay_pin_crossed
);
  // All pins charge at the same rate but cross at rising levels, so the rails come up one after another.
  logic [7:0] pin_level [lss_pkg::NUM_SEQ];
  wire charging = rail_delay_pin_source_en & ~rail_delay_pin_discharge_en;

  always_ff @(posedge clk or negedge nrst) begin
    for (int i = 0; i < lss_pkg::NUM_SEQ; i++) begin
      if (!nrst || !charging) begin
        pin_level[i] <= 8'h00;
      end else if (pin_level[i] != 8'hff) begin
        pin_level[i] <= pin_level[i] + 8'h01;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < lss_pkg::NUM_SEQ; i++) begin
      rail_delay_pin_crossed[i] = pin_level[i] >= 8'(8 * (i + 1));
    end
  end

  // An output is below its undervoltage level until its ramp has completed.
  assign rail_below_uv = ~soft_start_done & ~rail_ctrl_en | ~soft_start_done;
endmodule // lss_analog_model

// [bench/lss_supply_sequencer_test.sv]
// Self-checking testbench of the supply sequencer core with the analog side model.
// Assumes a 40 MHz clk; the full soft-start is too long to run, so only its first steps are timed.
`timescale 1ns/1ps
module lss_supply_sequencer_test;
  localparam int unsigned FT = 2;
  localparam int unsigned RT = 4;
  localparam int unsigned OCF = 4;
  localparam int TOL = 200;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic supply_lockout = 1'b0, turn_on_input = 1'b0, ordering_select_input = 1'b0, switching_rate_select = 1'b0;
  logic over_temp = 1'b0, current_sense_trip = 1'b0, pwm_high_req = 1'b0, pwm_low_req = 1'b0;
  logic supervisor_sense_input = 1'b0;
  logic [lss_pkg::NUM_RAILS-1:0] rail_below_uv, rail_ctrl_en, soft_start_done;
  logic [lss_pkg::NUM_SEQ-1:0] rail_delay_pin_crossed;
  logic [lss_pkg::NUM_RAILS*lss_pkg::REF_W-1:0] rail_ref_code;
  logic internal_5v_rail_en, switching_en, high_side_gate_drive, low_side_gate_drive;
  logic rail_delay_pin_source_en, rail_delay_pin_discharge_en, supervisor_reset_out, supervisor_reset_oe;
  logic fault_latch, thermal_latch;
  lss_pkg::lss_state_t state;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  lss_supply_sequencer #(.FAULT_TICKS(FT), .RESET_TICKS(RT), .OC_FILTER_CYCLES(OCF)) lss_supply_sequencer_inst (
    .clk, .nrst, .supply_lockout, .turn_on_input, .ordering_select_input, .switching_rate_select, .over_temp,
    .current_sense_trip, .rail_below_uv, .rail_delay_pin_crossed, .pwm_high_req, .pwm_low_req,
    .supervisor_sense_input, .internal_5v_rail_en, .switching_en, .high_side_gate_drive, .low_side_gate_drive,
    .rail_ctrl_en, .rail_ref_code, .soft_start_done, .rail_delay_pin_source_en, .rail_delay_pin_discharge_en,
    .supervisor_reset_out, .supervisor_reset_oe, .fault_latch, .thermal_latch, .state);

  lss_analog_model lss_analog_model_inst (
    .clk, .nrst, .rail_ctrl_en, .soft_start_done, .rail_delay_pin_source_en, .rail_delay_pin_discharge_en,
    .rail_below_uv, .rail_delay_pin_crossed);

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang counts as a failure and still reaches the closing report.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic oc_trip(input int n);
    @(posedge clk);
    current_sense_trip <= 1'b1;
    repeat (n) @(posedge clk);
    current_sense_trip <= 1'b0;
    tick(1);
  endtask

  task automatic t_ramp(input logic fast);
    int n;
    int exp;
    bit seen;
    bit seen5;
    n = 0;
    seen = 0;
    seen5 = 0;
    exp = fast ? int'(lss_pkg::TPS_FAST * lss_pkg::DIV_FAST) : int'(lss_pkg::TPS_SLOW * lss_pkg::DIV_SLOW);
    @(posedge clk);
    turn_on_input <= 1'b0;
    switching_rate_select <= fast;
    tick(2);
    check_val(8'(rail_ctrl_en), 8'h00, "rails off");
    check_bit(internal_5v_rail_en, 1'b1, "5v rail kept");
    check_bit(rail_delay_pin_discharge_en, 1'b1, "pins discharged");
    @(posedge clk);
    turn_on_input <= 1'b1;
    tick(1);
    check_bit(rail_ctrl_en[0], 1'b1, "buck enable");
    check_bit(switching_en, 1'b1, "switching");
    check_bit(rail_delay_pin_source_en, 1'b1, "pin source");
    check_val(8'(state), 8'(lss_pkg::LSS_SOFT), "soft state");
    check_val(8'(rail_ref_code[5:0]), 8'h00, "buck ref start");
    while (rail_ref_code[5:0] === 6'h00 && n < 8000) begin
      tick(1);
      n++;
      if (rail_ctrl_en[2] === 1'b1 && !seen) begin
        seen = 1;
        check_bit(rail_ctrl_en[5], 1'b0, "late rail early");
      end
      // The negative ramp shares the switching ticks, so it may step on the same edge as the buck.
      if (rail_ctrl_en[5] === 1'b1 && !seen5) begin
        seen5 = 1;
        check_val(8'(rail_ref_code[35:30]), 8'h20, "neg ref start");
      end
    end
    check_bit(n >= exp - TOL && n <= exp + TOL, 1'b1, "step period");
    check_val(8'(rail_ref_code[5:0]), 8'h01, "buck first step");
    check_val(8'(rail_ctrl_en[5:1]), 8'h1e, "rails during ramp");
    n = 0;
    while (rail_ref_code[35:30] === 6'h20 && n < 400) begin
      tick(1);
      n++;
    end
    check_val(8'(rail_ref_code[35:30]), 8'h1f, "neg first step");
    $display("ramp test done, fast %b", fast);
  endtask

  task automatic t_order_low();
    @(posedge clk);
    turn_on_input <= 1'b0;
    ordering_select_input <= 1'b0;
    tick(2);
    @(posedge clk);
    turn_on_input <= 1'b1;
    tick(100);
    check_val(8'(rail_ctrl_en[5:2]), 8'h00, "rails held");
    check_bit(rail_delay_pin_source_en, 1'b0, "no source");
    check_bit(rail_delay_pin_discharge_en, 1'b1, "discharge");
    @(posedge clk);
    ordering_select_input <= 1'b1;
    tick(100);
    check_val(8'(rail_ctrl_en[5:2]), 8'h0f, "rails on");
    $display("ordering test done");
  endtask

  task automatic t_fault();
    for (int k = 0; k < 2; k++) begin
      oc_trip(OCF - 1);
      tick(3);
      check_bit(fault_latch, 1'b0, "short trip");
      oc_trip(OCF);
      check_bit(fault_latch, 1'b1, "long trip");
      tick(1);
      check_val(8'(rail_ctrl_en), 8'h00, "rails shut");
      check_val(8'(state), 8'(lss_pkg::LSS_HALT), "halt state");
      check_bit(internal_5v_rail_en, 1'b1, "5v rail kept");
      check_bit(supervisor_reset_oe, 1'b1, "reset on fault");
      @(posedge clk);
      if (k == 0) ordering_select_input <= 1'b0;
      else turn_on_input <= 1'b0;
      @(posedge clk);
      if (k == 0) ordering_select_input <= 1'b1;
      else turn_on_input <= 1'b1;
      tick(2);
      check_bit(fault_latch, 1'b0, "fault cleared");
      tick(2);
      check_bit(rail_ctrl_en[0], 1'b1, "restart");
    end
    $display("fault test done");
  endtask

  task automatic t_lockout();
    @(posedge clk);
    pwm_high_req <= 1'b1;
    tick(3);
    check_bit(high_side_gate_drive, 1'b1, "high drive");
    oc_trip(OCF);
    @(posedge clk);
    supply_lockout <= 1'b1;
    pwm_low_req <= 1'b1;
    tick(2);
    check_bit(high_side_gate_drive, 1'b0, "high drive low");
    check_bit(low_side_gate_drive, 1'b0, "low drive low");
    check_bit(switching_en, 1'b0, "no switching");
    check_bit(fault_latch, 1'b0, "lockout clears fault");
    check_bit(supervisor_reset_oe, 1'b1, "reset on lockout");
    @(posedge clk);
    supply_lockout <= 1'b0;
    pwm_low_req <= 1'b0;
    tick(3);
    check_bit(rail_ctrl_en[0], 1'b1, "startup after release");
    @(posedge clk);
    over_temp <= 1'b1;
    tick(1);
    check_bit(thermal_latch, 1'b1, "thermal set");
    check_bit(internal_5v_rail_en, 1'b0, "5v rail off");
    @(posedge clk);
    over_temp <= 1'b0;
    turn_on_input <= 1'b0;
    ordering_select_input <= 1'b0;
    @(posedge clk);
    turn_on_input <= 1'b1;
    ordering_select_input <= 1'b1;
    tick(3);
    check_bit(thermal_latch, 1'b1, "thermal kept");
    check_val(8'(rail_ctrl_en), 8'h00, "rails off hot");
    check_bit(supervisor_reset_oe, 1'b1, "reset on thermal");
    @(posedge clk);
    supply_lockout <= 1'b1;
    tick(2);
    check_bit(thermal_latch, 1'b0, "power cycle clears");
    @(posedge clk);
    supply_lockout <= 1'b0;
    pwm_high_req <= 1'b0;
    tick(3);
    check_bit(internal_5v_rail_en, 1'b1, "5v rail back");
    check_bit(rail_ctrl_en[0], 1'b1, "restart");
    $display("lockout and thermal test done");
  endtask

  task automatic t_super();
    int n;
    int per;
    int exp;
    per = switching_rate_select ? int'(lss_pkg::DIV_FAST) : int'(lss_pkg::DIV_SLOW);
    exp = RT * per;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      supervisor_sense_input <= 1'b1;
      if (k == 1) begin
        tick(exp / 2);
        @(posedge clk);
        supervisor_sense_input <= 1'b0;
        @(posedge clk);
        supervisor_sense_input <= 1'b1;
      end
      n = 0;
      while (supervisor_reset_oe === 1'b1 && n < 2000) begin
        tick(1);
        n++;
      end
      // Only the phase of the first tick may shorten the wait, so a missed restart shows up.
      check_bit(n > exp - per && n <= exp, 1'b1, "reset timeout");
      @(posedge clk);
      supervisor_sense_input <= 1'b0;
      tick(2);
      check_bit(supervisor_reset_oe, 1'b1, "reset on sense low");
      check_bit(supervisor_reset_out, 1'b0, "reset drives low");
      check_bit(rail_ctrl_en[0], 1'b1, "rails unaffected");
    end
    $display("supervisor test done");
  endtask

  initial begin
    tick(4);
    check_val(8'(rail_ctrl_en), 8'h00, "reset enables");
    check_bit(rail_delay_pin_discharge_en, 1'b1, "reset discharge");
    check_bit(supervisor_reset_oe, 1'b1, "reset pin low");
    check_val(8'(rail_ref_code[35:30]), 8'h20, "reset neg ref");
    check_val(8'(state), 8'(lss_pkg::LSS_OFF), "reset state");
    @(posedge clk);
    nrst <= 1'b1;
    ordering_select_input <= 1'b1;
    tick(2);
    check_bit(internal_5v_rail_en, 1'b1, "5v rail up");
    $display("reset test done");
    t_ramp(1'b0);
    t_ramp(1'b1);
    t_order_low();
    t_fault();
    t_lockout();
    t_super();
    report_and_stop();
  end
endmodule // lss_supply_sequencer_test

// [common/lss_pkg.sv]
// Shared constants and types of the display supply sequencer core.
// Assumes a single 40 MHz system clock; all analog events arrive as comparator levels.
package lss_pkg;

  // System clock and switching rates.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SW_SLOW_HZ = 250_000;
  localparam int unsigned SW_FAST_HZ = 500_000;
  localparam int unsigned DIV_SLOW = CLK_HZ / SW_SLOW_HZ;
  localparam int unsigned DIV_FAST = CLK_HZ / SW_FAST_HZ;
  localparam int unsigned DIV_W = 8;

  // Soft-start ramp: 32 reference steps, whole ramp in switching cycles.
  localparam int unsigned SS_STEPS = 32;
  localparam int unsigned SS_CYCLES_SLOW = 1024;
  localparam int unsigned SS_CYCLES_FAST = 2048;
  localparam int unsigned TPS_SLOW = SS_CYCLES_SLOW / SS_STEPS;
  localparam int unsigned TPS_FAST = SS_CYCLES_FAST / SS_STEPS;
  localparam int unsigned REF_W = 6;
  localparam int unsigned TICK_W = 7;

  // Overcurrent transient filter, rounded up to whole clock cycles.
  localparam int unsigned OC_FILTER_NS = 50_000;
  localparam int unsigned OC_FILTER_CYC = (OC_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Fault timer and supervisor timeout lengths, in switching cycles.
  localparam int unsigned FAULT_TICKS_DEF = 64;
  localparam int unsigned RESET_TICKS_DEF = 256;
  localparam int unsigned CNT_W = 16;

  // Rail indices: step-down first, negative rail last.
  localparam int unsigned NUM_RAILS = 6;
  localparam int unsigned RAIL_BUCK = 0;
  localparam int unsigned RAIL_LOGIC = 1;
  localparam int unsigned RAIL_NEG = 5;
  localparam int unsigned NUM_SEQ = 4;

  typedef enum logic [1:0] {
    LSS_OFF  = 2'b00,
    LSS_SOFT = 2'b01,
    LSS_RUN  = 2'b11,
    LSS_HALT = 2'b10
  } lss_state_t;

endpackage

// [core/lss_softstart_ramp.sv]
// Soft-start reference ramp of one regulator: 32 steps paced by switching ticks.
// Assumes sw_tick is a one-cycle pulse per switching period and enable is registered.
`timescale 1ns/1ps
module lss_softstart_ramp #(
  parameter bit NEGATIVE = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic enable,
  input wire logic sw_tick,
  input wire logic rate_fast,
  // Ramp state
  output logic [lss_pkg::REF_W-1:0] ref_code,
  output logic done
);

  localparam logic [lss_pkg::REF_W-1:0] FULL = lss_pkg::REF_W'(lss_pkg::SS_STEPS);

  logic [lss_pkg::TICK_W-1:0] tick_cnt;
  logic [lss_pkg::REF_W-1:0] step;

  wire [lss_pkg::TICK_W-1:0] step_len = rate_fast ? lss_pkg::TICK_W'(lss_pkg::TPS_FAST)
                                                  : lss_pkg::TICK_W'(lss_pkg::TPS_SLOW);
  wire at_full = (step == FULL);
  wire step_end = sw_tick && (tick_cnt == step_len - 7'h01);
  // The negative rail starts at the top code and walks down to the low end point.
  wire [lss_pkg::REF_W-1:0] next_ref = NEGATIVE ? (FULL - step) : step;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 7'h00;
      step <= 6'h00;
    end else if (!enable) begin
      tick_cnt <= 7'h00;
      step <= 6'h00;
    end else if (sw_tick && !at_full) begin
      tick_cnt <= step_end ? 7'h00 : tick_cnt + 7'h01;
      step <= step_end ? step + 6'h01 : step;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_code <= NEGATIVE ? FULL : 6'h00;
    end else begin
      ref_code <= next_ref;
    end
  end

  assign done = enable && at_full;

endmodule // lss_softstart_ramp

// [core/lss_supply_sequencer.sv]
// Digital control core of a multi-rail display supply: gating, sequencing, soft-start,
// fault latches and the timed supervisor reset.
// Assumes all inputs are comparator levels already synchronous to clk.
// Contract
// - Turn-on low holds all regulators off
// - Turn-on rise clears faults, not thermal latch
// - Lockout stops switching, both gate drives low
// - Lockout release clears fault and thermal latches; here both clear while lockout is high, not on release
// - Step-down enabled only with all four conditions
// - Logic rail starts after step-down soft-start
// - Sequence block enables with step-down, ordering select high
// - Delay pins source or discharge per ordering select
// - Rails two to five enable on delay crossing
// - Positive references ramp up in 32 steps
// - Negative reference ramps down in 32 steps
// - Ramp lasts 1024 or 2048 switching cycles
// - Supervisor reset low while sense below threshold
// - Supervisor reset low on lockout, off, faults
// - Release only after full uninterrupted timeout
// - Supervisor reset feeds no other function
// - Undervoltage after soft-start runs fault timer
// - Persistent undervoltage latches fault, rails off
// - Ordering or turn-on rise clears fault latch
// - Over-temperature latches, kills everything incl. rail
// - Filtered overcurrent latches fault, rails off
`timescale 1ns/1ps
module lss_supply_sequencer #(
  parameter int unsigned FAULT_TICKS = lss_pkg::FAULT_TICKS_DEF,
  parameter int unsigned RESET_TICKS = lss_pkg::RESET_TICKS_DEF,
  parameter int unsigned OC_FILTER_CYCLES = lss_pkg::OC_FILTER_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Supply and control comparators
  input wire logic supply_lockout,
  input wire logic turn_on_input,
  input wire logic ordering_select_input,
  input wire logic switching_rate_select,
  input wire logic over_temp,
  input wire logic current_sense_trip,
  // Regulator monitors
  input wire logic [lss_pkg::NUM_RAILS-1:0] rail_below_uv,
  input wire logic [lss_pkg::NUM_SEQ-1:0] rail_delay_pin_crossed,
  // PWM requests from the current-mode loop
  input wire logic pwm_high_req,
  input wire logic pwm_low_req,
  // Supervisor sense comparator
  input wire logic supervisor_sense_input,
  // Supply and gate drive
  output logic internal_5v_rail_en,
  output logic switching_en,
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  // Regulator enables and references
  output logic [lss_pkg::NUM_RAILS-1:0] rail_ctrl_en,
  output logic [lss_pkg::NUM_RAILS*lss_pkg::REF_W-1:0] rail_ref_code,
  output logic [lss_pkg::NUM_RAILS-1:0] soft_start_done,
  // Delay pins
  output logic rail_delay_pin_source_en,
  output logic rail_delay_pin_discharge_en,
  // Supervisor reset, open drain
  output logic supervisor_reset_out,
  output logic supervisor_reset_oe,
  // Status
  output logic fault_latch,
  output logic thermal_latch,
  output lss_pkg::lss_state_t state
);

  if (FAULT_TICKS < 1 || FAULT_TICKS > 65535) begin : g_chk_fault
    $error("FAULT_TICKS out of range");
  end
  if (RESET_TICKS < 1 || RESET_TICKS > 65535) begin : g_chk_reset
    $error("RESET_TICKS out of range");
  end
  if (OC_FILTER_CYCLES < 1 || OC_FILTER_CYCLES > 65535) begin : g_chk_oc
    $error("OC_FILTER_CYCLES out of range");
  end

  localparam logic [lss_pkg::CNT_W-1:0] FAULT_LAST = lss_pkg::CNT_W'(FAULT_TICKS - 1);
  localparam logic [lss_pkg::CNT_W-1:0] RESET_LAST = lss_pkg::CNT_W'(RESET_TICKS - 1);
  localparam logic [lss_pkg::CNT_W-1:0] OC_LAST = lss_pkg::CNT_W'(OC_FILTER_CYCLES - 1);

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur && !prev;
  endfunction

  // Switching clock tick derived from the system clock.
  logic [lss_pkg::DIV_W-1:0] div_cnt;
  logic sw_tick;
  wire [lss_pkg::DIV_W-1:0] div_last = switching_rate_select ? lss_pkg::DIV_W'(lss_pkg::DIV_FAST - 1)
                                                              : lss_pkg::DIV_W'(lss_pkg::DIV_SLOW - 1);
  wire div_wrap = (div_cnt >= div_last);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 8'h00;
      sw_tick <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
      sw_tick <= div_wrap;
    end
  end

  // Edge detection on the two clearing inputs.
  logic turn_on_prev;
  logic ordering_prev;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      turn_on_prev <= 1'b0;
      ordering_prev <= 1'b0;
    end else begin
      turn_on_prev <= turn_on_input;
      ordering_prev <= ordering_select_input;
    end
  end
  wire turn_on_rise = rise(turn_on_input, turn_on_prev);
  wire ordering_rise = rise(ordering_select_input, ordering_prev);

  // Enable conditions.
  wire supply_ok = !supply_lockout && turn_on_input;
  wire go = supply_ok && !fault_latch && !thermal_latch;
  wire seq_on = go && ordering_select_input;
  wire logic_go = go && soft_start_done[lss_pkg::RAIL_BUCK];
  wire [lss_pkg::NUM_SEQ-1:0] seq_go = {lss_pkg::NUM_SEQ{seq_on}} & rail_delay_pin_crossed;
  wire [lss_pkg::NUM_RAILS-1:0] next_rail_en = {seq_go, logic_go, go};

  // Soft-start ramps, one per regulator; only the last one walks downward.
  for (genvar i = 0; i < lss_pkg::NUM_RAILS; i++) begin : g_ramp
    lss_softstart_ramp #(
      .NEGATIVE(i == lss_pkg::RAIL_NEG)
    ) u_ramp (
      .clk(clk),
      .nrst(nrst),
      .enable(rail_ctrl_en[i]),
      .sw_tick(sw_tick),
      .rate_fast(switching_rate_select),
      .ref_code(rail_ref_code[i*lss_pkg::REF_W +: lss_pkg::REF_W]),
      .done(soft_start_done[i])
    );
  end

  // Undervoltage fault timer, only on rails past soft-start and while supply is valid.
  logic [lss_pkg::CNT_W-1:0] uv_cnt;
  wire uv_any = supply_ok && |(rail_below_uv & soft_start_done & rail_ctrl_en);
  wire uv_expire = uv_any && sw_tick && (uv_cnt == FAULT_LAST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uv_cnt <= 16'h0000;
    end else if (!uv_any) begin
      uv_cnt <= 16'h0000;
    end else if (sw_tick && uv_cnt != FAULT_LAST) begin
      uv_cnt <= uv_cnt + 16'h0001;
    end
  end

  // Overcurrent qualification: a trip must persist for the whole filter.
  logic [lss_pkg::CNT_W-1:0] oc_cnt;
  wire oc_set = current_sense_trip && (oc_cnt == OC_LAST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_cnt <= 16'h0000;
    end else if (!current_sense_trip) begin
      oc_cnt <= 16'h0000;
    end else if (oc_cnt != OC_LAST) begin
      oc_cnt <= oc_cnt + 16'h0001;
    end
  end

  // Latches: a set in the clearing cycle wins.
  wire fault_set = uv_expire || oc_set;
  wire fault_clear = supply_lockout || turn_on_rise || ordering_rise;
  wire next_fault = fault_set ? 1'b1 : (fault_clear ? 1'b0 : fault_latch);
  // Thermal only clears through a supply power cycle, never through turn-on.
  wire next_thermal = over_temp ? 1'b1 : (supply_lockout ? 1'b0 : thermal_latch);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_latch <= 1'b0;
      thermal_latch <= 1'b0;
    end else begin
      fault_latch <= next_fault;
      thermal_latch <= next_thermal;
    end
  end

  // Sequencing state.
  lss_pkg::lss_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      lss_pkg::LSS_OFF: begin
        if (go) next_state = lss_pkg::LSS_SOFT;
      end
      lss_pkg::LSS_SOFT: begin
        if (!go) next_state = (fault_latch || thermal_latch) ? lss_pkg::LSS_HALT : lss_pkg::LSS_OFF;
        else if (soft_start_done[lss_pkg::RAIL_BUCK]) next_state = lss_pkg::LSS_RUN;
      end
      lss_pkg::LSS_RUN: begin
        if (!go) next_state = (fault_latch || thermal_latch) ? lss_pkg::LSS_HALT : lss_pkg::LSS_OFF;
      end
      lss_pkg::LSS_HALT: begin
        if (!fault_latch && !thermal_latch) next_state = lss_pkg::LSS_OFF;
      end
      default: next_state = lss_pkg::LSS_OFF;
    endcase
  end

  // Outputs that steer the analog stages are all registered.
  wire next_switch = go;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= lss_pkg::LSS_OFF;
      rail_ctrl_en <= 6'h00;
      switching_en <= 1'b0;
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
      internal_5v_rail_en <= 1'b0;
      rail_delay_pin_source_en <= 1'b0;
      rail_delay_pin_discharge_en <= 1'b1;
    end else begin
      state <= next_state;
      rail_ctrl_en <= next_rail_en;
      switching_en <= next_switch;
      high_side_gate_drive <= next_switch && pwm_high_req && !pwm_low_req;
      low_side_gate_drive <= next_switch && pwm_low_req;
      internal_5v_rail_en <= !next_thermal;
      rail_delay_pin_source_en <= seq_on;
      rail_delay_pin_discharge_en <= !seq_on;
    end
  end

  // Supervisor reset: nothing else in the block reads its state.
  logic [lss_pkg::CNT_W-1:0] sup_cnt;
  logic sup_released;
  wire sup_hold = !supervisor_sense_input || supply_lockout || !turn_on_input
                  || fault_latch || thermal_latch;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sup_cnt <= 16'h0000;
      sup_released <= 1'b0;
    end else if (sup_hold) begin
      sup_cnt <= 16'h0000;
      sup_released <= 1'b0;
    end else if (sw_tick && !sup_released) begin
      sup_cnt <= (sup_cnt == RESET_LAST) ? sup_cnt : sup_cnt + 16'h0001;
      sup_released <= (sup_cnt == RESET_LAST);
    end
  end

  assign supervisor_reset_out = 1'b0;
  assign supervisor_reset_oe = !sup_released;

  // Helper: clock cycles from step-down enable to end of its ramp.
  logic [19:0] ss_len;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ss_len <= 20'h00000;
    end else begin
      ss_len <= rail_ctrl_en[lss_pkg::RAIL_BUCK] ? ss_len + 20'h00001 : 20'h00000;
    end
  end
  localparam int unsigned SS_CLK = lss_pkg::SS_CYCLES_SLOW * lss_pkg::DIV_SLOW;

  a_off_when_low: assert property (@(posedge clk) disable iff (!nrst)
    !turn_on_input |=> rail_ctrl_en == 6'h00) else $error("rail enabled with turn-on low");
  a_thermal_kept: assert property (@(posedge clk) disable iff (!nrst)
    thermal_latch && !supply_lockout |=> thermal_latch && !internal_5v_rail_en)
    else $error("thermal latch lost without power cycle");
  a_lockout_gates: assert property (@(posedge clk) disable iff (!nrst)
    supply_lockout |=> !switching_en && !high_side_gate_drive && !low_side_gate_drive)
    else $error("gate drive active in lockout");
  a_lockout_clears: assert property (@(posedge clk) disable iff (!nrst)
    supply_lockout && !over_temp && !current_sense_trip |=> !thermal_latch && !fault_latch)
    else $error("latch not cleared in lockout");
  a_buck_cond: assert property (@(posedge clk) disable iff (!nrst)
    rail_ctrl_en[0] |-> $past(supply_ok) && !$past(fault_latch) && !$past(thermal_latch))
    else $error("step-down enabled without all conditions");
  a_logic_after: assert property (@(posedge clk) disable iff (!nrst)
    $rose(rail_ctrl_en[1]) |-> soft_start_done[0]) else $error("logic rail before step-down ramp end");
  a_seq_delay: assert property (@(posedge clk) disable iff (!nrst)
    $rose(rail_ctrl_en[2]) |-> $past(rail_delay_pin_crossed[0]) && rail_ctrl_en[0] && rail_delay_pin_source_en)
    else $error("rail enabled without delay crossing");
  a_ramp_length: assert property (@(posedge clk) disable iff (!nrst)
    $rose(soft_start_done[0]) |-> ss_len >= 20'(SS_CLK - 200) && ss_len <= 20'(SS_CLK + 200))
    else $error("soft-start length wrong");
  a_neg_ends_low: assert property (@(posedge clk) disable iff (!nrst)
    soft_start_done[5] |=> rail_ref_code[35:30] == 6'h00 || !rail_ctrl_en[5])
    else $error("negative ramp not at low end");
  a_reset_held: assert property (@(posedge clk) disable iff (!nrst)
    sup_hold |=> supervisor_reset_oe [*2]) else $error("supervisor reset released while held");
  a_fault_off: assert property (@(posedge clk) disable iff (!nrst)
    fault_latch |=> rail_ctrl_en == 6'h00 && internal_5v_rail_en == !thermal_latch)
    else $error("regulators on with fault latched");
  a_oc_filter: assert property (@(posedge clk) disable iff (!nrst)
    $rose(fault_latch) && !$past(uv_expire) |-> $past(oc_cnt) == OC_LAST)
    else $error("overcurrent latched before filter");

  c_full_start: cover property (@(posedge clk) disable iff (!nrst) $rose(rail_ctrl_en[5]));
  c_uv_fault: cover property (@(posedge clk) disable iff (!nrst) $rose(fault_latch) && $past(uv_expire));
  c_reset_release: cover property (@(posedge clk) disable iff (!nrst) $fell(supervisor_reset_oe));
  c_thermal: cover property (@(posedge clk) disable iff (!nrst) $rose(thermal_latch));

endmodule // lss_supply_sequencer
